// ### src/sie_defines.vh
/*
  Constants of the two-wire serial engine: clock rate, bit timing,
  rate selections and the event status codes.
  Assumes inclusion by bare name from the engine source.
*/
`ifndef SIE_DEFINES_VH
`define SIE_DEFINES_VH

// ************************************************************
// clock and bit timing
// ************************************************************
`define SIE_CLK_MHZ 250
// quarter of one bit period, in ns, for each speed class
`define SIE_QTR_STD_NS 2500
`define SIE_QTR_FAST_NS 625
`define SIE_QTR_HS_NS 301
// least times round up to whole mclk cycles
`define SIE_NS2CYC(ns) ((((ns) * `SIE_CLK_MHZ) + 999) / 1000)
`define SIE_QTR_STD_CYC `SIE_NS2CYC(`SIE_QTR_STD_NS)
`define SIE_QTR_FAST_CYC `SIE_NS2CYC(`SIE_QTR_FAST_NS)
`define SIE_QTR_HS_CYC `SIE_NS2CYC(`SIE_QTR_HS_NS)

// ************************************************************
// rate selections
// ************************************************************
`define SIE_RATE_STD 2'h0
`define SIE_RATE_FAST 2'h1
`define SIE_RATE_HS 2'h2

// ************************************************************
// event status codes
// ************************************************************
`define SIE_ST_NONE 4'h0
`define SIE_ST_M_ADDR_ACK 4'h1
`define SIE_ST_M_ADDR_NACK 4'h2
`define SIE_ST_M_TX_ACK 4'h3
`define SIE_ST_M_TX_NACK 4'h4
`define SIE_ST_M_RX 4'h5
`define SIE_ST_S_ADDR 4'h6
`define SIE_ST_S_GCALL 4'h7
`define SIE_ST_S_RX 4'h8
`define SIE_ST_S_TX_ACK 4'h9
`define SIE_ST_S_TX_NACK 4'hA
`define SIE_ST_ARB_LOST 4'hB
`define SIE_ST_STOP 4'hC

`endif

// ### src/sie_i2c_engine.v
/*
  Two-wire serial engine, master and slave, open-drain bus pins.
  Assumes external pull-ups, a host that steers it through plain ports,
  and pins asynchronous to mclk (two-flop synchronised here).
*/
// Contract
// R1 - bytes are eight bits, most significant bit first on the data line
// R2 - master originates transfers and makes clock; slave only stretches it
// R3 - first byte after start: 7-bit address plus direction bit, 1 = read
// R4 - master clock speeds: standard 100k, fast 400k, high speed 833k
// R5 - master waits after releasing clock until the line really rises
// R6 - either side may hold clock low after a byte, for unlimited time
// R7 - pins only pull low or release; released lines are read back
// R8 - master reading low while releasing data has lost arbitration
// R9 - on arbitration loss switch at once to slave and still match address
// R10 - start is data falling while clock high
// R11 - stop is data rising while clock high
// R12 - data changes only while clock low, stable while clock high
// R13 - ninth bit: receiver pulls data low to acknowledge, else not
// R14 - only addressed slave acknowledges, then each accepted data byte
// R15 - master reader leaves last byte unacknowledged; slave then stops sending
// R16 - master ends a transfer with stop or repeated start
// R17 - no limit on bytes per transfer
// R18 - master waits for an idle bus before its start
// R19 - one engine acts as master or slave on a multi-master bus
// R20 - events reported by a flag usable as interrupt or polled
// R21 - after reset: master-receiver, both pins floating
// R22 - slave recognises all-zero broadcast write address and flags it
// R23 - bus inputs synchronised to mclk before detecting events
`include "sie_defines.vh"

module sie_i2c_engine (
  input wire mclk,
  input wire reset,
  input wire en,
  input wire [1:0] rate_sel,
  input wire [6:0] own_addr,
  input wire ack_en,
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_go,
  input wire [7:0] tx_byte,
  input wire sda_i,
  input wire scl_i,
  output wire sda_o,
  output reg sda_oe_q,
  output wire scl_o,
  output reg scl_oe_q,
  output reg [7:0] rx_byte_q,
  output reg evt_q,
  output reg [3:0] status_q,
  output reg is_master_q,
  output reg is_tx_q,
  output reg busy_q,
  output reg arb_lost_q
);

  // ************************************************************
  // states and timing
  // ************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_BITS = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_END = 3'h4;
  // counts are worked out as integers, then cut to the counter width
  localparam integer QI_STD = `SIE_QTR_STD_CYC;
  localparam integer QI_FAST = `SIE_QTR_FAST_CYC;
  localparam integer QI_HS = `SIE_QTR_HS_CYC;
  localparam [10:0] Q_STD = QI_STD[10:0];
  localparam [10:0] Q_FAST = QI_FAST[10:0];
  localparam [10:0] Q_HS = QI_HS[10:0];

  reg sda_m, sda_s, sda_p, scl_m, scl_s, scl_p;
  reg [2:0] st_q;
  reg ph_q;
  reg [10:0] cnt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg samp_q, addr_ph_q, ack_q, rw_q, stop_q, pend_q, gc_q;
  reg [10:0] qtr;
  reg sda_d;

  // pins are open drain: the only level ever driven is low
  assign sda_o = 1'b0; // R7
  assign scl_o = 1'b0; // R7

  // ************************************************************
  // synchronisers and bus event detection
  // ************************************************************
  // the first stage feeds only the second; edges use stages two and three
  always @(posedge mclk) begin
    if (reset) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
    end else begin
      sda_m <= sda_i; // R23
      sda_s <= sda_m;
      sda_p <= sda_s;
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
    end
  end

  wire start_det = scl_s & scl_p & sda_p & ~sda_s; // R10
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s; // R11
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;

  // quarter bit length from the selected speed class
  always @* begin
    case (rate_sel)
      `SIE_RATE_FAST: qtr = Q_FAST; // R4
      `SIE_RATE_HS: qtr = Q_HS; // R4
      default: qtr = Q_STD; // R4
    endcase
  end

  wire [10:0] q_m1 = qtr - 11'h001;
  wire [10:0] h_m1 = {qtr[9:0], 1'b0} - 11'h001;

  // ************************************************************
  // bit engine
  // ************************************************************
  // we own the data line on our data bits, or on the ack bit as receiver
  wire own_bit = (is_tx_q & (bit_q < 4'h8)) | (~is_tx_q & (bit_q == 4'h8));
  wire want_low = own_bit & ((bit_q == 4'h8) ? ack_q : ~sh_q[7]); // R1 R13
  // master sets data a quarter into clock low; slave whenever clock is low
  wire upd = is_master_q ? (~ph_q & (cnt_q >= qtr)) : ~scl_s; // R12
  // master samples mid-high, only once the clock really rose
  wire m_high = is_master_q & ph_q & scl_s; // R5
  wire samp_ev = (st_q == S_BITS) & (is_master_q ? (m_high & (cnt_q == q_m1)) : scl_rise);
  wire end_ev = (st_q == S_BITS) & (is_master_q ? (m_high & (cnt_q == h_m1)) : scl_fall);
  wire [7:0] nb = {sh_q[6:0], samp_q};
  wire lose = is_master_q & own_bit & ~sda_oe_q & ~sda_s; // R8
  wire hit = (nb[7:1] == own_addr) | (nb == 8'h00); // R14 R22

  // pin drive follows state; registered so the pins come from flip-flops
  always @* begin
    case (st_q)
      S_START: sda_d = 1'b1;
      S_BITS: sda_d = upd ? want_low : sda_oe_q;
      S_END: sda_d = (~ph_q & (cnt_q >= qtr)) ? stop_q : sda_oe_q;
      default: sda_d = 1'b0;
    endcase
  end

  wire scl_d = (st_q == S_HOLD) | (((st_q == S_BITS) | (st_q == S_END)) & is_master_q & ~ph_q);

  always @(posedge mclk) begin
    if (reset | ~en) begin
      sda_oe_q <= 1'b0; // R21
      scl_oe_q <= 1'b0; // R21
    end else begin
      sda_oe_q <= sda_d; // R7
      scl_oe_q <= scl_d; // R2 R6
    end
  end

  // ************************************************************
  // control state machine
  // ************************************************************
  always @(posedge mclk) begin
    if (reset | ~en) begin
      st_q <= S_IDLE;
      ph_q <= 1'b0;
      cnt_q <= 11'h000;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      samp_q <= 1'b1;
      addr_ph_q <= 1'b0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      stop_q <= 1'b0;
      pend_q <= 1'b0;
      gc_q <= 1'b0;
      rx_byte_q <= 8'h00;
      evt_q <= 1'b0;
      status_q <= `SIE_ST_NONE;
      is_master_q <= 1'b1; // R21
      is_tx_q <= 1'b0; // R21
      busy_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else begin
      // bus busy between any start and the next stop
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;
      // clears come first so that an event in the same cycle wins
      if (cmd_go | cmd_stop | cmd_start) begin
        evt_q <= 1'b0;
        arb_lost_q <= 1'b0;
      end
      if (cmd_start & ~((st_q == S_HOLD) & is_master_q))
        pend_q <= 1'b1;
      // master clock phases: low then high, high waits for the real line
      if (((st_q == S_BITS) & is_master_q) | (st_q == S_END)) begin
        if (~ph_q) begin
          cnt_q <= (cnt_q == h_m1) ? 11'h000 : cnt_q + 11'h001;
          if (cnt_q == h_m1)
            ph_q <= 1'b1;
        end else if (~scl_s) begin
          cnt_q <= 11'h000; // R5 R6
        end else begin
          cnt_q <= (cnt_q == h_m1) ? 11'h000 : cnt_q + 11'h001;
          if (cnt_q == h_m1)
            ph_q <= 1'b0;
        end
      end
      case (st_q)
        S_IDLE: begin
          cnt_q <= 11'h000;
          if (start_det) begin
            // someone else started: listen as slave for the address
            st_q <= S_BITS; // R19
            is_master_q <= 1'b0;
            is_tx_q <= 1'b0;
            addr_ph_q <= 1'b1;
            bit_q <= 4'hF; // start's own clock fall ends a dummy bit, wraps to 0
          end else if (pend_q & ~busy_q & ~cmd_start) begin
            st_q <= S_START; // R18
            pend_q <= 1'b0;
          end
        end
        S_START: begin
          // data pulled low here, clock released: hold the start setup
          cnt_q <= cnt_q + 11'h001;
          if (cnt_q == h_m1) begin
            st_q <= S_BITS; // R2 R3 R10
            cnt_q <= 11'h000;
            ph_q <= 1'b0;
            bit_q <= 4'h0;
            sh_q <= tx_byte;
            rw_q <= tx_byte[0]; // R3
            addr_ph_q <= 1'b1;
            is_master_q <= 1'b1;
            is_tx_q <= 1'b1;
          end
        end
        S_BITS: begin
          if (samp_ev) begin
            samp_q <= sda_s;
            if (lose) begin
              // drop the bus; in the address phase keep the shifted bits and go on as slave, else report and idle
              is_master_q <= 1'b0; // R8 R9
              is_tx_q <= 1'b0;
              arb_lost_q <= 1'b1;
              if (~addr_ph_q) begin
                st_q <= S_IDLE;
                evt_q <= 1'b1; // R20
                status_q <= `SIE_ST_ARB_LOST;
              end
            end
          end
          if (~is_master_q & start_det) begin
            // repeated start: next byte is an address again
            bit_q <= 4'hF;
            addr_ph_q <= 1'b1;
            is_tx_q <= 1'b0;
          end else if (~is_master_q & stop_det) begin
            st_q <= S_IDLE; // R11
            is_master_q <= 1'b1;
            if (~addr_ph_q) begin
              evt_q <= 1'b1;
              status_q <= `SIE_ST_STOP;
            end
          end else if (end_ev & (bit_q != 4'h8)) begin
            sh_q <= nb; // R1
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              rx_byte_q <= nb;
              ack_q <= ack_en; // R13 R15
              if (addr_ph_q & ~is_master_q) begin
                rw_q <= nb[0];
                gc_q <= (nb == 8'h00);
                if (~hit | (nb == 8'h01))
                  st_q <= S_IDLE; // R14
              end
            end
          end else if (end_ev) begin
            // ninth bit over: report and stretch the clock, unless a refused slave sender lets go
            bit_q <= 4'h0; // R17
            addr_ph_q <= 1'b0;
            evt_q <= 1'b1; // R20
            st_q <= S_HOLD; // R6
            if (addr_ph_q)
              is_tx_q <= is_master_q ? ~rw_q : rw_q; // R3
            if (is_master_q & addr_ph_q)
              status_q <= samp_q ? `SIE_ST_M_ADDR_NACK : `SIE_ST_M_ADDR_ACK;
            else if (is_master_q & is_tx_q)
              status_q <= samp_q ? `SIE_ST_M_TX_NACK : `SIE_ST_M_TX_ACK;
            else if (is_master_q)
              status_q <= `SIE_ST_M_RX;
            else if (addr_ph_q)
              status_q <= gc_q ? `SIE_ST_S_GCALL : `SIE_ST_S_ADDR; // R22
            else if (~is_tx_q)
              status_q <= `SIE_ST_S_RX;
            else if (~samp_q)
              status_q <= `SIE_ST_S_TX_ACK;
            else begin
              // master refused the byte: release the bus, send no more
              status_q <= `SIE_ST_S_TX_NACK; // R15
              st_q <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          cnt_q <= 11'h000;
          ph_q <= 1'b0;
          if (is_master_q & (cmd_stop | cmd_start)) begin
            st_q <= S_END; // R16
            stop_q <= cmd_stop;
          end else if (cmd_go) begin
            st_q <= S_BITS;
            sh_q <= tx_byte;
          end
        end
        S_END: begin
          // stop: data low then released in clock high; restart: reverse
          if (ph_q & scl_s & (cnt_q == h_m1)) begin
            st_q <= stop_q ? S_IDLE : S_START; // R16
            cnt_q <= 11'h000;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule // sie_i2c_engine

// ### verification/sie_i2c_engine_assertions.sv
/*
  Port checker for the two-wire engine, bound to every engine instance.
  Assumes one clock domain and a synchronous active-high reset.
*/
`include "sie_defines.vh"
module sie_i2c_engine_assertions (
  input wire mclk,
  input wire reset,
  input wire en,
  input wire [1:0] rate_sel,
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_go,
  input wire sda_oe_q,
  input wire scl_oe_q,
  input wire evt_q,
  input wire [3:0] status_q,
  input wire is_master_q,
  input wire is_tx_q,
  input wire busy_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire no_cmd = !cmd_go && !cmd_stop && !cmd_start;
  property p_rst;
    $fell(reset) |-> !sda_oe_q && !scl_oe_q && !evt_q && is_master_q && !is_tx_q && !busy_q;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_en;
    !en |=> !sda_oe_q && !scl_oe_q;
  endproperty
  a_en: assert property (p_en) else $error("pins held while disabled");
  // start from idle: pend, then START, then the data pull shows three edges on
  property p_start;
    cmd_start && en && !busy_q && !evt_q |-> ##3 sda_oe_q && !scl_oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start not issued");
  property p_hold;
    evt_q && is_master_q && scl_oe_q && no_cmd |=> scl_oe_q;
  endproperty
  a_hold: assert property (p_hold) else $error("clock hold dropped");
  property p_keep;
    evt_q && en && no_cmd |=> evt_q && $stable(status_q);
  endproperty
  a_keep: assert property (p_keep) else $error("event lost");
  property p_go;
    cmd_go && en |=> !evt_q;
  endproperty
  a_go: assert property (p_go) else $error("event not cleared");
  // a slave only pulls the clock to stretch after a byte
  property p_slv;
    !is_master_q && $rose(scl_oe_q) |-> ##[0:2] evt_q;
  endproperty
  a_slv: assert property (p_slv) else $error("slave drove clock");
  // bound only holds for the fastest rate and stretches under a microsecond
  property p_stop;
    cmd_stop && evt_q && is_master_q && scl_oe_q && rate_sel == `SIE_RATE_HS
      |-> ##[1:600] !scl_oe_q && !sda_oe_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not finished");
  c_maddr: cover property (evt_q && status_q == `SIE_ST_M_ADDR_ACK);
  c_saddr: cover property (evt_q && status_q == `SIE_ST_S_ADDR);
  c_gcall: cover property (evt_q && status_q == `SIE_ST_S_GCALL);
endmodule // sie_i2c_engine_assertions

bind sie_i2c_engine sie_i2c_engine_assertions sie_i2c_engine_assertions_inst (.mclk, .reset,
  .en, .rate_sel, .cmd_start, .cmd_stop, .cmd_go, .sda_oe_q, .scl_oe_q, .evt_q, .status_q,
  .is_master_q, .is_tx_q, .busy_q);

// ### verification/sie_bus_partner.sv
/*
  Far-side slave model: acks its address on a write and every later
  byte, may stretch the clock after them. Assumes pulled-up lines.
*/
module sie_bus_partner #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic sda,
  input wire logic scl,
  output logic sda_pull,
  output logic scl_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  logic sel;
  logic first;
  logic [7:0] bytes[$];
  int stops = 0;
  int stretch_ns = 0;
  initial begin
    sda_pull = 0;
    scl_pull = 0;
  end
  // a frame runs from a start until a stop cuts it short anywhere
  always begin
    @(negedge sda iff scl === 1'b1);
    first = 1;
    sel = 0;
    fork : frame
      forever begin
        for (int i = 0; i < 8; i++) begin
          @(posedge scl);
          got = {got[6:0], sda};
        end
        @(negedge scl);
        bytes.push_back(got);
        if (first) sel = (got === {ADDR, 1'b0});
        first = 0;
        sda_pull = sel;
        @(negedge scl);
        sda_pull = 0;
        if (sel && stretch_ns > 0) begin
          scl_pull = 1;
          #(stretch_ns);
          scl_pull = 0;
        end
      end
      begin
        @(posedge sda iff scl === 1'b1);
        stops++;
      end
    join_any
    disable frame;
    sda_pull = 0;
    scl_pull = 0;
  end
endmodule // sie_bus_partner

// ### verification/sie_i2c_engine_bench.sv
/*
  Bench of the two-wire engine: master writes to a slave model, a
  refused address, slave receive and broadcast from a bench master.
  Assumes pull-ups on both lines, modelled by the wired-AND below.
*/
`include "sie_defines.vh"
module sie_i2c_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] PADDR = 7'h2A;
  localparam logic [6:0] OADDR = 7'h3C;
  logic mclk = 0, reset = 1, en = 0, ack_en = 0, cmd_start = 0, cmd_stop = 0, cmd_go = 0;
  logic [1:0] rate_sel = `SIE_RATE_HS;
  logic [6:0] own_addr = OADDR;
  logic [7:0] tx_byte = 8'h00;
  logic m_sda = 0, m_scl = 0, ack;
  wire p_sda, p_scl, sda_oe_q, scl_oe_q, evt_q, is_master_q, is_tx_q, busy_q;
  wire arb_lost_q, sda_o, scl_o;
  wire [7:0] rx_byte_q;
  wire [3:0] status_q;
  // open-drain lines read high only when nobody pulls
  wire sda = !(sda_oe_q || p_sda || m_sda);
  wire scl = !(scl_oe_q || p_scl || m_scl);
  int n_fail = 0, n_compared = 0, cyc = 0;
  sie_i2c_engine sie_i2c_engine_inst (.mclk, .reset, .en, .rate_sel, .own_addr, .ack_en,
    .cmd_start, .cmd_stop, .cmd_go, .tx_byte, .sda_i(sda), .scl_i(scl), .sda_o, .sda_oe_q,
    .scl_o, .scl_oe_q, .rx_byte_q, .evt_q, .status_q, .is_master_q, .is_tx_q, .busy_q,
    .arb_lost_q);
  sie_bus_partner #(.ADDR(PADDR)) sie_bus_partner_inst (.sda, .scl, .sda_pull(p_sda),
    .scl_pull(p_scl));
  initial forever #2 mclk = ~mclk;
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1;
    @(negedge mclk) s = 0;
  endtask
  task automatic wait_evt;
    repeat (20000) begin
      @(negedge mclk);
      if (evt_q === 1'b1) return;
    end
    chk(0, "no event");
  endtask
  task automatic wait_idle;
    repeat (5000) begin
      @(negedge mclk);
      if (busy_q === 1'b0) return;
    end
    chk(0, "bus stays busy");
  endtask
  // bench as a second master, about 125 ns a bit, obeying stretches
  task automatic mb_bit(input logic b, output logic s);
    m_sda = !b;
    #31 m_scl = 0;
    wait (scl === 1'b1);
    #31 s = sda;
    #31 m_scl = 1;
    #31;
  endtask
  task automatic m_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) mb_bit(b[i], s);
    mb_bit(1, s);
    a = !s;
  endtask
  task automatic m_start;
    #62 m_sda = 1;
    #62 m_scl = 1;
  endtask
  task automatic m_stop;
    m_sda = 1;
    #31 m_scl = 0;
    wait (scl === 1'b1);
    #62 m_sda = 0;
    #62;
  endtask
  task automatic t_mwrite;
    int st;
    st = sie_bus_partner_inst.stops;
    sie_bus_partner_inst.bytes.delete();
    sie_bus_partner_inst.stretch_ns = 1000;
    tx_byte = {PADDR, 1'b0};
    pulse(cmd_start);
    wait_evt();
    chk(status_q === `SIE_ST_M_ADDR_ACK && busy_q === 1'b1, "address not acked");
    tx_byte = 8'hA5;
    pulse(cmd_go);
    wait_evt();
    chk(status_q === `SIE_ST_M_TX_ACK, "data not acked");
    chk(sie_bus_partner_inst.bytes[0] === {PADDR, 1'b0}, "address bits");
    chk(sie_bus_partner_inst.bytes[1] === 8'hA5, "data bits");
    pulse(cmd_stop);
    wait_idle();
    chk(sie_bus_partner_inst.stops == st + 1 && sda === 1'b1, "no stop");
  endtask
  task automatic t_nack;
    rate_sel = `SIE_RATE_FAST;
    tx_byte = {7'h11, 1'b0};
    pulse(cmd_start);
    wait_evt();
    chk(status_q === `SIE_ST_M_ADDR_NACK, "nack not seen");
    pulse(cmd_stop);
    wait_idle();
    chk(sda === 1'b1 && scl === 1'b1, "lines held");
    rate_sel = `SIE_RATE_HS;
  endtask
  task automatic t_slave(input logic [6:0] a, input logic [3:0] code);
    m_start();
    m_byte({a, 1'b0}, ack);
    chk(ack === 1'b1, "slave address not acked");
    wait_evt();
    // the stretch pull follows the event by one edge
    @(negedge mclk);
    chk(status_q === code && is_master_q === 1'b0 && scl_oe_q === 1'b1, "slave event");
    pulse(cmd_go);
    m_byte(8'h5A, ack);
    wait_evt();
    chk(ack === 1'b1 && rx_byte_q === 8'h5A && status_q === `SIE_ST_S_RX, "slave rx");
    s_stop();
  endtask
  // end a slave transfer: continue, stop, see the stop event, clear it
  task automatic s_stop;
    pulse(cmd_go);
    m_stop();
    wait_idle();
    chk(evt_q === 1'b1 && status_q === `SIE_ST_STOP, "no stop event");
    pulse(cmd_go);
  endtask
  // engine and bench master address at once; the bench wins on the first bit
  task automatic t_arb;
    logic s;
    logic [7:0] b;
    b = {OADDR, 1'b0};
    tx_byte = 8'hFE;
    pulse(cmd_start);
    @(negedge scl);
    m_scl = 1; // hold the low phase alongside the engine
    m_sda = 1; // our address starts with a zero, the engine's with a one
    #700 m_scl = 0;
    wait (scl === 1'b1);
    #400 m_scl = 1;
    chk(arb_lost_q === 1'b1 && is_master_q === 1'b0 && scl_oe_q === 1'b0, "no loss");
    for (int i = 6; i >= 0; i--) mb_bit(b[i], s);
    mb_bit(1, s);
    chk(s === 1'b0, "own address not acked after loss");
    wait_evt();
    @(negedge mclk);
    chk(status_q === `SIE_ST_S_ADDR && rx_byte_q === b && scl_oe_q === 1'b1, "loser");
    s_stop();
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    reset = 0;
    @(negedge mclk);
    chk(is_master_q === 1'b1 && is_tx_q === 1'b0 && sda_oe_q === 1'b0, "reset");
    chk(sda_o === 1'b0 && scl_o === 1'b0, "pins drive high");
    en = 1;
    ack_en = 1;
    t_mwrite();
    t_nack();
    t_slave(OADDR, `SIE_ST_S_ADDR);
    t_slave(7'h00, `SIE_ST_S_GCALL);
    t_arb();
    m_start();
    m_byte({7'h55, 1'b0}, ack);
    chk(ack === 1'b0 && evt_q === 1'b0, "stray address acked");
    m_stop();
    stop_test();
  end
endmodule // sie_i2c_engine_bench
